// ### core/fob_pkg.sv
// Shared constants and types for the flash option byte loader
package fob_pkg;

  // Program-memory locations of the two option bytes
  localparam logic [15:0] FOB_OPT0_ADDR = 16'h0000;
  localparam logic [15:0] FOB_OPT1_ADDR = 16'h0001;

  // Page that holds the option bytes; erasing it wipes them
  localparam logic [7:0] FOB_OPT_PAGE = 8'h00;

  // Value of an erased flash byte
  localparam logic [7:0] FOB_ERASED_BYTE = 8'hFF;

  // Field positions in option byte zero
  localparam int FOB_B0_WDT_ACTION = 7;
  localparam int FOB_B0_WDT_FORCE = 6;
  localparam int FOB_B0_BO_FORCE = 3;
  localparam int FOB_B0_READ_LOCK = 2;
  localparam int FOB_B0_WRITE_LOCK = 0;

  // Field position in option byte one
  localparam int FOB_B1_XTAL_OFF = 4;

  // Reserved bits, forced to ones on every read
  localparam logic [7:0] FOB_OPT0_RSVD_MASK = 8'h32;
  localparam logic [7:0] FOB_OPT1_RSVD_MASK = 8'hEF;

  // Idle value of the read-back data port
  localparam logic [7:0] FOB_RD_IDLE = 8'h00;

  // Decoded settings handed to the consumers
  typedef struct packed {
    logic wdt_action;
    logic wdt_force_on;
    logic bo_force_on;
    logic read_lock;
    logic write_lock;
    logic xtal_off;
  } fob_cfg_s;

  // Settings of erased flash: every field at one
  localparam fob_cfg_s FOB_CFG_ERASED = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  // One fetch request towards the flash array
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } fob_fetch_s;

  // Loader sequence states
  typedef enum logic [1:0] {
    FOB_LD_FETCH0,
    FOB_LD_FETCH1,
    FOB_LD_READY
  } fob_ld_e;

endpackage : fob_pkg

// ### core/fob_opt_decode.sv
// Field decoder for the two raw option bytes
`timescale 1ns/1ns

module fob_opt_decode
  import fob_pkg::*;
(
  // Raw bytes as stored in flash
  input wire logic [7:0] raw0,
  input wire logic [7:0] raw1,
  // Decoded settings
  output fob_cfg_s cfg,
  // Read-back views with reserved bits forced high
  output logic [7:0] view0,
  output logic [7:0] view1
);

  ////////////////////////////////////////////////////////////////////////
  // Field extraction
  always_comb
  begin
    cfg.wdt_action = raw0[FOB_B0_WDT_ACTION];
    cfg.wdt_force_on = raw0[FOB_B0_WDT_FORCE];
    cfg.bo_force_on = raw0[FOB_B0_BO_FORCE];
    cfg.read_lock = raw0[FOB_B0_READ_LOCK];
    cfg.write_lock = raw0[FOB_B0_WRITE_LOCK];
    cfg.xtal_off = raw1[FOB_B1_XTAL_OFF];
  end

  ////////////////////////////////////////////////////////////////////////
  // Reserved bits always read as ones, whatever was programmed
  assign view0 = raw0 | FOB_OPT0_RSVD_MASK;
  assign view1 = raw1 | FOB_OPT1_RSVD_MASK;

endmodule : fob_opt_decode

// ### core/fob_loader.sv
// Flash option byte loader: fetch at reset, decode, hold, apply
`timescale 1ns/1ns

// Notes on behaviour
// - Options live at program bytes 0000H, 0001H
// - Action bit low: timeout raises interrupt request
// - Action bit high: timeout forces system reset
// - Force bit low: watchdog runs, cannot stop
// - Force bit high: arm starts, reset/recovery stops
// - Byte zero bits 5:4 read as ones
// - Brown-out off in stop only with power bit
// - Brown-out forced on: always enabled, even stop
// - Read lock low: code blocked, debugger limited
// - Read lock high: code and debugger open
// - Write lock low: user program/erase refused
// - Write lock high: program and erase allowed
// - Erased ones are the default settings
// - Byte one bits 7:5 read as ones
// - Crystal bit enables oscillator, not clock select
// - Crystal bit low: oscillator on, long reset
// - Crystal bit high: oscillator off, short reset
// - Byte one bits 3:0 read as ones
// - Reset never alters the stored option bytes
// - Page zero erase wipes both option bytes

module fob_loader
  import fob_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Option fetch from the flash array
  output logic FLASH_RD_REQ,
  output logic [15:0] FLASH_RD_ADDR,
  input wire logic FLASH_RD_ACK,
  input wire logic [7:0] FLASH_RD_DATA,
  // Program and erase requests
  input wire logic PROG_REQ,
  input wire logic [15:0] PROG_ADDR,
  input wire logic [7:0] PROG_DATA,
  input wire logic PAGE_ERASE_REQ,
  input wire logic [7:0] PAGE_ERASE_NUM,
  input wire logic MASS_ERASE_REQ,
  input wire logic DBG_MASS_ERASE_REQ,
  output logic PROG_GRANT,
  output logic ERASE_GRANT,
  output logic REQ_REFUSED,
  // Option byte read-back
  input wire logic OPT_RD_EN,
  input wire logic [15:0] OPT_RD_ADDR,
  output logic OPT_RD_VALID,
  output logic [7:0] OPT_RD_DATA,
  // Watchdog
  input wire logic WDT_ARM,
  input wire logic WDT_TIMEOUT,
  input wire logic STOP_RECOVERY,
  output logic WDT_RUN,
  output logic WDT_IRQ,
  output logic WDT_SYS_RESET,
  // Brown-out
  input wire logic STOP_MODE,
  input wire logic PWR_BO_OFF,
  output logic BO_ENABLE,
  // Protection
  output logic CODE_ACCESS_OK,
  output logic DBG_FULL_CMDS,
  // Oscillator and status
  output logic XTAL_ENABLE,
  output logic RESET_LONG,
  output logic CFG_VALID
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  fob_ld_e ld_q; // Loader state
  fob_fetch_s fetch; // Current fetch request
  logic [7:0] img0_q; // Mirror of stored byte zero
  logic [7:0] img1_q; // Mirror of stored byte one
  fob_cfg_s cfg_q; // Settings held until reset
  fob_cfg_s img_cfg; // Settings decoded from the mirror
  logic [7:0] view0; // Byte zero as software reads it
  logic [7:0] view1; // Byte one as software reads it
  logic ready; // Settings are valid
  logic prog_ok; // User program is allowed now
  logic erase_ok; // User erase is allowed now
  logic user_erase; // A user page or mass erase request
  logic wipe; // Options are being erased
  logic prog_hit0; // Granted program hits byte zero
  logic prog_hit1; // Granted program hits byte one
  logic wdt_run_q; // Watchdog running
  logic wdt_irq_q; // Interrupt pulse
  logic wdt_rst_q; // Reset pulse
  logic prog_grant_q; // Program grant pulse
  logic erase_grant_q; // Erase grant pulse
  logic refused_q; // Refusal pulse
  logic rd_valid_q; // Read answer pulse
  logic [7:0] rd_data_q; // Read answer data

  ////////////////////////////////////////////////////////////////////////
  // Decoder of the mirrored bytes
  fob_opt_decode u_decode (
    .raw0 (img0_q),
    .raw1 (img1_q),
    .cfg (img_cfg),
    .view0 (view0),
    .view1 (view1)
  );

  assign ready = (ld_q == FOB_LD_READY);

  ////////////////////////////////////////////////////////////////////////
  // Fetch request: one byte at a time, held until the array acknowledges
  always_comb
  begin
    fetch.req = (ld_q == FOB_LD_FETCH0) || (ld_q == FOB_LD_FETCH1);
    fetch.addr = (ld_q == FOB_LD_FETCH1) ? FOB_OPT1_ADDR : FOB_OPT0_ADDR;
  end

  assign FLASH_RD_REQ = fetch.req;
  assign FLASH_RD_ADDR = fetch.addr;

  ////////////////////////////////////////////////////////////////////////
  // Loader sequence, restarted by every reset
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ld_q <= FOB_LD_FETCH0;
    end
    else
    begin
      unique case (ld_q)
        FOB_LD_FETCH0:
        begin
          if (FLASH_RD_ACK)
          begin
            ld_q <= FOB_LD_FETCH1;
          end
        end
        FOB_LD_FETCH1:
        begin
          if (FLASH_RD_ACK)
          begin
            ld_q <= FOB_LD_READY;
          end
        end
        FOB_LD_READY: ld_q <= FOB_LD_READY; // Parked until the next reset
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program and erase gating by the held write lock
  assign user_erase = PAGE_ERASE_REQ | MASS_ERASE_REQ;
  assign prog_ok = ready & cfg_q.write_lock;
  assign erase_ok = ready & cfg_q.write_lock;
  assign prog_hit0 = PROG_REQ & prog_ok & (PROG_ADDR == FOB_OPT0_ADDR);
  assign prog_hit1 = PROG_REQ & prog_ok & (PROG_ADDR == FOB_OPT1_ADDR);
  // Debugger mass erase ignores the write lock
  assign wipe = (DBG_MASS_ERASE_REQ & ready)
    | (erase_ok & MASS_ERASE_REQ)
    | (erase_ok & PAGE_ERASE_REQ & (PAGE_ERASE_NUM == FOB_OPT_PAGE));

  // Grant and refusal pulses, one cycle after the request
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      prog_grant_q <= 1'b0;
      erase_grant_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else
    begin
      prog_grant_q <= PROG_REQ & prog_ok;
      erase_grant_q <= (user_erase & erase_ok) | (DBG_MASS_ERASE_REQ & ready);
      refused_q <= (PROG_REQ & ~prog_ok) | (user_erase & ~erase_ok)
        | (DBG_MASS_ERASE_REQ & ~ready);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mirror of the stored bytes; reset leaves it alone since the fetch
  // refreshes it, and programming can only clear bits, as in the array
  always_ff @(posedge CLK)
  begin
    if (!SYS_RST && ld_q == FOB_LD_FETCH0 && FLASH_RD_ACK)
    begin
      img0_q <= FLASH_RD_DATA;
    end
    else if (!SYS_RST && wipe)
    begin
      img0_q <= FOB_ERASED_BYTE;
    end
    else if (!SYS_RST && prog_hit0)
    begin
      img0_q <= img0_q & PROG_DATA;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!SYS_RST && ld_q == FOB_LD_FETCH1 && FLASH_RD_ACK)
    begin
      img1_q <= FLASH_RD_DATA;
    end
    else if (!SYS_RST && wipe)
    begin
      img1_q <= FOB_ERASED_BYTE;
    end
    else if (!SYS_RST && prog_hit1)
    begin
      img1_q <= img1_q & PROG_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Held settings: erased defaults in reset, captured once at load end.
  // Later programming changes the mirror only, so consumers never see a
  // setting move under them before the next reset.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cfg_q <= FOB_CFG_ERASED;
    end
    else if (ld_q == FOB_LD_FETCH1 && FLASH_RD_ACK)
    begin
      cfg_q <= '{img_cfg.wdt_action, img_cfg.wdt_force_on, img_cfg.bo_force_on,
                 img_cfg.read_lock, img_cfg.write_lock, FLASH_RD_DATA[FOB_B1_XTAL_OFF]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read-back with reserved bits forced high; other addresses answer idle
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q <= FOB_RD_IDLE;
    end
    else
    begin
      rd_valid_q <= OPT_RD_EN;
      if (OPT_RD_EN && OPT_RD_ADDR == FOB_OPT0_ADDR)
      begin
        rd_data_q <= view0;
      end
      else if (OPT_RD_EN && OPT_RD_ADDR == FOB_OPT1_ADDR)
      begin
        rd_data_q <= view1;
      end
      else if (OPT_RD_EN)
      begin
        rd_data_q <= FOB_RD_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog enable
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wdt_run_q <= 1'b0;
    end
    else if (ready && !cfg_q.wdt_force_on)
    begin
      wdt_run_q <= 1'b1;
    end
    else if (ready && STOP_RECOVERY)
    begin
      wdt_run_q <= 1'b0;
    end
    else if (ready && WDT_ARM)
    begin
      wdt_run_q <= 1'b1;
    end
  end

  // Timeout steering; the CPU decides on its own whether to take the IRQ
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      wdt_irq_q <= 1'b0;
      wdt_rst_q <= 1'b0;
    end
    else
    begin
      wdt_irq_q <= WDT_TIMEOUT & wdt_run_q & ~cfg_q.wdt_action;
      wdt_rst_q <= WDT_TIMEOUT & wdt_run_q & cfg_q.wdt_action;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign PROG_GRANT = prog_grant_q;
  assign ERASE_GRANT = erase_grant_q;
  assign REQ_REFUSED = refused_q;
  assign OPT_RD_VALID = rd_valid_q;
  assign OPT_RD_DATA = rd_data_q;
  assign WDT_RUN = wdt_run_q;
  assign WDT_IRQ = wdt_irq_q;
  assign WDT_SYS_RESET = wdt_rst_q;
  // Brown-out stays on unless not forced, in stop, and the power bit agrees
  assign BO_ENABLE = cfg_q.bo_force_on | ~STOP_MODE | ~PWR_BO_OFF;
  // Protection is closed until the settings are known
  assign CODE_ACCESS_OK = ready & cfg_q.read_lock;
  assign DBG_FULL_CMDS = ready & cfg_q.read_lock;
  // Oscillator enable only; clock selection is left to software
  assign XTAL_ENABLE = ready & ~cfg_q.xtal_off;
  assign RESET_LONG = ready & ~cfg_q.xtal_off;
  assign CFG_VALID = ready;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Fetch of byte zero followed by fetch of byte one
  sequence s_got0;
    FLASH_RD_REQ && FLASH_RD_ADDR == FOB_OPT0_ADDR && FLASH_RD_ACK;
  endsequence
  sequence s_ask1;
    FLASH_RD_REQ && FLASH_RD_ADDR == FOB_OPT1_ADDR;
  endsequence

  chk_fetch_order: assert property (s_got0 |=> s_ask1)
    else $error("byte one not fetched after byte zero");

  chk_cfg_hold: assert property (CFG_VALID && $past(CFG_VALID) |-> $stable(cfg_q))
    else $error("held settings moved after load");

  chk_wdt_irq: assert property (WDT_TIMEOUT && WDT_RUN && !cfg_q.wdt_action |=> WDT_IRQ && !WDT_SYS_RESET)
    else $error("timeout did not raise interrupt");
  chk_wdt_reset: assert property (WDT_TIMEOUT && WDT_RUN && cfg_q.wdt_action |=> WDT_SYS_RESET && !WDT_IRQ)
    else $error("timeout did not force reset");

  chk_wdt_forced: assert property (CFG_VALID && !cfg_q.wdt_force_on |=> WDT_RUN [*2])
    else $error("forced watchdog not running");
  chk_wdt_armed: assert property (CFG_VALID && cfg_q.wdt_force_on && !WDT_RUN && !WDT_ARM |=> !WDT_RUN)
    else $error("watchdog started without arm");

  chk_bo_forced: assert property (cfg_q.bo_force_on && STOP_MODE |-> BO_ENABLE)
    else $error("forced brown-out dropped in stop");
  chk_bo_off: assert property (!cfg_q.bo_force_on && STOP_MODE && PWR_BO_OFF |-> !BO_ENABLE)
    else $error("brown-out not released in stop");

  chk_prog_lock: assert property (PROG_REQ && CFG_VALID && !cfg_q.write_lock |=> !PROG_GRANT && REQ_REFUSED)
    else $error("locked program request granted");

  chk_rsvd_read: assert property (OPT_RD_EN && OPT_RD_ADDR == FOB_OPT0_ADDR
      |=> OPT_RD_VALID && (OPT_RD_DATA & FOB_OPT0_RSVD_MASK) == FOB_OPT0_RSVD_MASK)
    else $error("reserved bits of byte zero read low");

  chk_read_lock: assert property (CFG_VALID && !cfg_q.read_lock |-> !CODE_ACCESS_OK && !DBG_FULL_CMDS)
    else $error("read lock did not close access");
  chk_xtal_mode: assert property (CFG_VALID |-> XTAL_ENABLE == !cfg_q.xtal_off && RESET_LONG == XTAL_ENABLE)
    else $error("crystal enable disagrees with option");

endmodule : fob_loader

// ### bench/fob_flash_model.sv
// Behavioural flash array that answers the loader's option fetches
`timescale 1ns/1ns

module fob_flash_model
  import fob_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Fetch link from the loader
  input wire logic FLASH_RD_REQ,
  input wire logic [15:0] FLASH_RD_ADDR,
  output logic FLASH_RD_ACK,
  output logic [7:0] FLASH_RD_DATA,
  // Stored option bytes and answer latency, set by the bench
  input wire logic [7:0] OPT0,
  input wire logic [7:0] OPT1,
  input wire logic [3:0] ACK_DELAY
);
  // Cycles waited on the current request
  logic [3:0] wait_q = 4'h0;
  // Data line; toggles when nothing is being answered
  logic [7:0] data_q = 8'h5A;
  logic ack_q = 1'b0;

  assign FLASH_RD_ACK = ack_q;
  assign FLASH_RD_DATA = data_q;

  ////////////////////////////////////////////////////////////////////////
  // Answer one request after the programmed delay, then drop ack
  always @(posedge CLK)
  begin
    if (SYS_RST || !FLASH_RD_REQ || ack_q)
    begin
      // Idle: data is garbage, so a stale sample cannot pass by luck
      wait_q <= 4'h0;
      ack_q <= 1'b0;
      data_q <= ~data_q;
    end
    else if (wait_q == ACK_DELAY)
    begin
      // Bytes were written with reserved bits high by the bench
      ack_q <= 1'b1;
      data_q <= (FLASH_RD_ADDR == FOB_OPT1_ADDR) ? OPT1 : OPT0;
    end
    else
    begin
      wait_q <= wait_q + 4'h1;
      data_q <= ~data_q;
    end
  end
endmodule : fob_flash_model

// ### bench/fob_loader_tb.sv
// Self-checking testbench for the flash option byte loader
`timescale 1ns/1ns

module fob_loader_tb;
  import fob_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Stimulus, all given a value at time zero
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PROG_REQ = 1'b0, PAGE_ERASE_REQ = 1'b0, MASS_ERASE_REQ = 1'b0, DBG_MASS_ERASE_REQ = 1'b0;
  logic [15:0] PROG_ADDR = 16'h0000, OPT_RD_ADDR = 16'h0000;
  logic [7:0] PROG_DATA = 8'h00, PAGE_ERASE_NUM = 8'h00;
  logic OPT_RD_EN = 1'b0, WDT_ARM = 1'b0, WDT_TIMEOUT = 1'b0, STOP_RECOVERY = 1'b0;
  logic STOP_MODE = 1'b0, PWR_BO_OFF = 1'b0;
  // Contents of the modelled flash and its answer latency
  logic [7:0] opt0 = 8'hFF, opt1 = 8'hFF;
  logic [3:0] ack_delay = 4'h0;
  // Design outputs
  logic FLASH_RD_REQ, FLASH_RD_ACK, PROG_GRANT, ERASE_GRANT, REQ_REFUSED, OPT_RD_VALID;
  logic WDT_RUN, WDT_IRQ, WDT_SYS_RESET, BO_ENABLE, CODE_ACCESS_OK, DBG_FULL_CMDS;
  logic XTAL_ENABLE, RESET_LONG, CFG_VALID;
  logic [15:0] FLASH_RD_ADDR;
  logic [7:0] FLASH_RD_DATA, OPT_RD_DATA;
  int num_errors = 0;
  int samples_checked = 0;

  always #5 CLK = ~CLK;

  fob_loader dut_u (.CLK, .SYS_RST, .FLASH_RD_REQ, .FLASH_RD_ADDR, .FLASH_RD_ACK, .FLASH_RD_DATA,
    .PROG_REQ, .PROG_ADDR, .PROG_DATA, .PAGE_ERASE_REQ, .PAGE_ERASE_NUM, .MASS_ERASE_REQ,
    .DBG_MASS_ERASE_REQ, .PROG_GRANT, .ERASE_GRANT, .REQ_REFUSED, .OPT_RD_EN, .OPT_RD_ADDR,
    .OPT_RD_VALID, .OPT_RD_DATA, .WDT_ARM, .WDT_TIMEOUT, .STOP_RECOVERY, .WDT_RUN, .WDT_IRQ,
    .WDT_SYS_RESET, .STOP_MODE, .PWR_BO_OFF, .BO_ENABLE, .CODE_ACCESS_OK, .DBG_FULL_CMDS,
    .XTAL_ENABLE, .RESET_LONG, .CFG_VALID);

  fob_flash_model flash_u (.CLK, .SYS_RST, .FLASH_RD_REQ, .FLASH_RD_ADDR, .FLASH_RD_ACK,
    .FLASH_RD_DATA, .OPT0(opt0), .OPT1(opt1), .ACK_DELAY(ack_delay));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Reset, let the loader fetch both bytes, then judge the applied settings
  task automatic load(input logic [7:0] b0, input logic [7:0] b1, input logic [3:0] dly);
    int n;
    @(posedge CLK);
    opt0 <= b0;
    opt1 <= b1;
    ack_delay <= dly;
    SYS_RST <= 1'b1;
    repeat (3) @(negedge CLK);
    check("cfg_valid_in_reset", CFG_VALID, 1'b0);
    check("fetch_req_in_reset", FLASH_RD_REQ, 1'b1);
    check("fetch_addr_in_reset", FLASH_RD_ADDR, FOB_OPT0_ADDR);
    @(posedge CLK);
    SYS_RST <= 1'b0;
    n = 0;
    // Bounded wait: two fetches at most a few cycles each
    while (CFG_VALID !== 1'b1 && n < 40)
    begin
      @(negedge CLK);
      n++;
    end
    check("cfg_valid", CFG_VALID, 1'b1);
    check("fetch_done", FLASH_RD_REQ, 1'b0);
    @(negedge CLK);
    check("wdt_run", WDT_RUN, !b0[FOB_B0_WDT_FORCE]);
    check("code_access", CODE_ACCESS_OK, b0[FOB_B0_READ_LOCK]);
    check("dbg_full", DBG_FULL_CMDS, b0[FOB_B0_READ_LOCK]);
    check("xtal_enable", XTAL_ENABLE, !b1[FOB_B1_XTAL_OFF]);
    check("reset_long", RESET_LONG, !b1[FOB_B1_XTAL_OFF]);
  endtask : load

  // Kind 0 program, 1 page erase, 2 user mass erase, 3 debugger mass erase
  task automatic flash_op(input int k, input logic [7:0] num, input logic exp_g, input logic exp_r);
    @(posedge CLK);
    PROG_REQ <= (k == 0);
    PAGE_ERASE_REQ <= (k == 1);
    MASS_ERASE_REQ <= (k == 2);
    DBG_MASS_ERASE_REQ <= (k == 3);
    PROG_ADDR <= {8'h00, num};
    PAGE_ERASE_NUM <= num;
    @(posedge CLK);
    PROG_REQ <= 1'b0;
    PAGE_ERASE_REQ <= 1'b0;
    MASS_ERASE_REQ <= 1'b0;
    DBG_MASS_ERASE_REQ <= 1'b0;
    @(negedge CLK);
    check("grant", (k == 0) ? PROG_GRANT : ERASE_GRANT, exp_g);
    check("refused", REQ_REFUSED, exp_r);
  endtask : flash_op

  // One watchdog event pulse, then the three watchdog outputs
  task automatic wdt(input logic a, input logic t, input logic r, input logic run, input logic irq, input logic rst);
    @(posedge CLK);
    WDT_ARM <= a;
    WDT_TIMEOUT <= t;
    STOP_RECOVERY <= r;
    @(posedge CLK);
    WDT_ARM <= 1'b0;
    WDT_TIMEOUT <= 1'b0;
    STOP_RECOVERY <= 1'b0;
    @(negedge CLK);
    check("wdt_run", WDT_RUN, run);
    check("wdt_irq", WDT_IRQ, irq);
    check("wdt_sys_reset", WDT_SYS_RESET, rst);
  endtask : wdt

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK);
    OPT_RD_EN <= 1'b1;
    OPT_RD_ADDR <= a;
    @(posedge CLK);
    OPT_RD_EN <= 1'b0;
    @(negedge CLK);
    check("rd_valid", OPT_RD_VALID, 1'b1);
    check("rd_data", OPT_RD_DATA, exp);
  endtask : rd

  task automatic bo(input logic stop, input logic pwr, input logic exp);
    @(posedge CLK);
    STOP_MODE <= stop;
    PWR_BO_OFF <= pwr;
    @(negedge CLK);
    check("bo_enable", BO_ENABLE, exp);
  endtask : bo

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_erased;
    load(8'hFF, 8'hFF, 4'h3);
    bo(1'b1, 1'b1, 1'b1);
    wdt(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    wdt(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wdt(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    wdt(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    flash_op(0, 8'h05, 1'b1, 1'b0);
    flash_op(2, 8'h00, 1'b1, 1'b0);
    $display("test erased defaults done");
  endtask : test_erased

  task automatic test_locked;
    // Every field cleared, reserved bits kept high
    load(8'h32, 8'hEF, 4'h0);
    wdt(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    wdt(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    bo(1'b1, 1'b1, 1'b0);
    bo(1'b1, 1'b0, 1'b1);
    bo(1'b0, 1'b1, 1'b1);
    flash_op(0, 8'h00, 1'b0, 1'b1);
    flash_op(1, 8'h00, 1'b0, 1'b1);
    flash_op(2, 8'h00, 1'b0, 1'b1);
    flash_op(3, 8'h00, 1'b1, 1'b0);
    rd(FOB_OPT0_ADDR, 8'hFF);
    check("code_access_held", CODE_ACCESS_OK, 1'b0);
    $display("test locked options done");
  endtask : test_locked

  task automatic test_readback;
    load(8'hB7, 8'hFF, 4'h1);
    rd(FOB_OPT0_ADDR, 8'hB7);
    // A careless writer clears reserved bits; reads must still show ones
    flash_op(0, 8'h00, 1'b1, 1'b0);
    rd(FOB_OPT0_ADDR, 8'h32);
    flash_op(0, 8'h01, 1'b1, 1'b0);
    rd(FOB_OPT1_ADDR, 8'hEF);
    rd(16'h0002, FOB_RD_IDLE);
    check("code_access_held", CODE_ACCESS_OK, 1'b1);
    flash_op(1, 8'h01, 1'b1, 1'b0);
    rd(FOB_OPT0_ADDR, 8'h32);
    flash_op(1, FOB_OPT_PAGE, 1'b1, 1'b0);
    rd(FOB_OPT0_ADDR, 8'hFF);
    rd(FOB_OPT1_ADDR, 8'hFF);
    load(8'hB7, 8'hFF, 4'h0);
    rd(FOB_OPT0_ADDR, 8'hB7);
    $display("test read-back done");
  endtask : test_readback

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20) @(posedge CLK);
    test_erased();
    test_locked();
    test_readback();
    print_verdict();
  end

  // Tests need well under a thousand cycles; this cuts a hang short
  initial
  begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    print_verdict();
  end
endmodule : fob_loader_tb
